// file: include/ldsf_defines.svh
/*
 * offsets, field positions, reset values and counts of the led driver
 * status flag group; assumes an 8-bit register address space.
 */
`ifndef LDSF_DEFINES_SVH
`define LDSF_DEFINES_SVH

// ***********************************
// register offsets
// ***********************************
`define LDSF_OFF_PRIMARY     8'h70
`define LDSF_OFF_SECONDARY   8'h71
`define LDSF_OFF_SUPPLY      8'h72
`define LDSF_OFF_CONV_RESULT 8'h73
`define LDSF_OFF_CONV_CHAN   8'h62
`define LDSF_OFF_MASK        8'h64
`define LDSF_OFF_CONTROL     8'h7C
`define LDSF_OFF_IRQ_STATUS  8'h7D
`define LDSF_OFF_IRQ_MASK    8'h7E

// ***********************************
// primary fault status fields
// ***********************************
`define LDSF_PRI_REF   6
`define LDSF_PRI_SAFE  5
`define LDSF_PRI_OUT   4
`define LDSF_PRI_PRE   3
`define LDSF_PRI_TSD   2
`define LDSF_PRI_POR   1
`define LDSF_PRI_ERR   0
`define LDSF_PRI_RESET 8'h03

// ***********************************
// secondary status fields
// ***********************************
`define LDSF_SEC_PIN   5
`define LDSF_SEC_PROG  4
`define LDSF_SEC_LOW   3
`define LDSF_SEC_DONE  2
`define LDSF_SEC_DIAG  1
`define LDSF_SEC_CRC   0

// ***********************************
// fault mask fields
// ***********************************
`define LDSF_MSK_REF   7
`define LDSF_MSK_CRC   6
`define LDSF_MSK_SHORT 5
`define LDSF_MSK_OPEN  4
`define LDSF_MSK_TSD   3

// ***********************************
// control, interrupt, widths
// ***********************************
`define LDSF_CTL_CLEAR_POR 0
`define LDSF_CHAN_W        5
`define LDSF_IRQ_W         6

`endif

// file: include/ldsf_pkg.sv
/*
 * types of the led driver status flag group; assumes nothing else.
 */
package ldsf_pkg;
   typedef logic [7:0] ldsf_byte_t;
   typedef logic [4:0] ldsf_chan_t;
endpackage

// file: hdl/ldsf_status_flags.sv
/*
 * status flag register group of a multichannel led driver, with the
 * conversion channel, fault mask, control and interrupt registers it needs.
 * assumes fault and event inputs come from logic on the same clock; only
 * the fail-safe pin is asynchronous. register port: one-cycle strobes,
 * read data in the cycle after the read strobe.
 *
 * register map:
 *   0x62 conversion channel, bits 4-0, a write starts a conversion
 *   0x64 fault mask: 7 ref, 6 integrity, 5 short, 4 open, 3 shutdown
 *   0x70 primary fault status, read-only
 *   0x71 secondary event status, read-only
 *   0x72 supply measurement, read-only
 *   0x73 conversion result, a read clears the done flag
 *   0x7C control: bit 0 written as one clears the power-on flag
 *   0x7D interrupt status, a read clears it
 *   0x7E interrupt mask, one enables
 * interrupt bits: 5 ref, 4 channel fault, 3 shutdown, 2 conversion done,
 * 1 diagnostic done, 0 programming done.
 */
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ps
`include "ldsf_defines.svh"

module ldsf_status_flags
   import ldsf_pkg::*;
#(
   parameter int CHAN_W = `LDSF_CHAN_W
) (
   input  wire logic       clock,
   input  wire logic       reset,
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_write,
   input  wire logic       reg_read,
   output logic [7:0]      reg_rdata,
   input  wire logic       ref_fault,
   input  wire logic       failsafe_mode,
   input  wire logic       open_fault,
   input  wire logic       short_fault,
   input  wire logic       thermal_prewarn,
   input  wire logic       thermal_shutdown,
   input  wire logic       failsafe_input_pin,
   input  wire logic       nvm_program_done,
   input  wire logic       low_supply,
   input  wire logic       conversion_complete,
   input  wire logic [7:0] conversion_value,
   input  wire logic       conversion_is_supply,
   input  wire logic       diag_run_done,
   input  wire logic       nvm_check_fail,
   output logic            conversion_start,
   output logic [4:0]      conversion_channel,
   output logic            error_out,
   output logic            irq
);

   // ***********************************
   // parameter checks
   // ***********************************
   // the channel register and read mux fit a 5-bit field only
   if (CHAN_W != 5) begin : g_chan_w_bad
      $error("conversion channel field must be 5 bits");
   end

   // the interrupt logic below is laid out for six event bits
   if (`LDSF_IRQ_W != 6) begin : g_irq_w_bad
      $error("interrupt field must be 6 bits");
   end

   // ***********************************
   // pin synchroniser
   // ***********************************
   logic pin_meta_r;
   logic failsafe_pin_level;

   // only the second flop is read; the first may still be settling
   always_ff @(posedge clock) begin
      pin_meta_r         <= failsafe_input_pin;
      failsafe_pin_level <= pin_meta_r;
   end

   // ***********************************
   // access decode
   // ***********************************
   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      hit = (a == off);
   endfunction

   logic wr_chan;
   logic wr_mask;
   logic wr_ctl;
   logic wr_imask;
   logic rd_result;
   logic rd_istat;

   assign wr_chan   = reg_write && hit(reg_addr, `LDSF_OFF_CONV_CHAN);
   assign wr_mask   = reg_write && hit(reg_addr, `LDSF_OFF_MASK);
   assign wr_ctl    = reg_write && hit(reg_addr, `LDSF_OFF_CONTROL);
   assign wr_imask  = reg_write && hit(reg_addr, `LDSF_OFF_IRQ_MASK);
   assign rd_result = reg_read && hit(reg_addr, `LDSF_OFF_CONV_RESULT);
   assign rd_istat  = reg_read && hit(reg_addr, `LDSF_OFF_IRQ_STATUS);

   // ***********************************
   // control registers
   // ***********************************
   ldsf_byte_t mask_r;
   ldsf_byte_t irq_mask_r;

   always_ff @(posedge clock) begin
      if (reset) begin
         mask_r <= 8'h00;
      end else if (wr_mask) begin
         mask_r <= reg_wdata;
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         irq_mask_r <= 8'h00;
      end else if (wr_imask) begin
         irq_mask_r <= {2'h0, reg_wdata[5:0]};
      end
   end

   // ***********************************
   // conversion request
   // ***********************************
   // write starts conversion
   always_ff @(posedge clock) begin
      if (reset) begin
         conversion_channel <= 5'h00;
         conversion_start   <= 1'b0;
      end else begin
         conversion_start <= wr_chan;
         if (wr_chan) begin
            conversion_channel <= reg_wdata[4:0];
         end
      end
   end

   // ***********************************
   // power-on flag
   // ***********************************
   logic por_flag_r;
   logic err_now;

   always_ff @(posedge clock) begin
      if (reset) begin
         por_flag_r <= 1'b1;
      end else if (wr_ctl && reg_wdata[`LDSF_CTL_CLEAR_POR]) begin
         por_flag_r <= 1'b0;
      end
   end

   // ***********************************
   // error summary
   // ***********************************
   logic       nvm_fail_r;
   logic [4:0] err_src;
   logic [4:0] err_mask;
   logic [4:0] err_live;

   assign err_src  = {ref_fault, nvm_fail_r, short_fault, open_fault, thermal_shutdown};
   assign err_mask = {mask_r[`LDSF_MSK_REF], mask_r[`LDSF_MSK_CRC], mask_r[`LDSF_MSK_SHORT],
                      mask_r[`LDSF_MSK_OPEN], mask_r[`LDSF_MSK_TSD]};

   for (genvar i = 0; i < 5; i++) begin : g_err
      assign err_live[i] = err_src[i] && !err_mask[i];
   end

   assign err_now = |err_live;

   // ***********************************
   // primary fault status
   // ***********************************
   ldsf_byte_t primary_r;

   always_ff @(posedge clock) begin
      if (reset) begin
         primary_r <= `LDSF_PRI_RESET;
      end else begin
         primary_r                <= 8'h00;
         primary_r[`LDSF_PRI_REF] <= ref_fault;
         primary_r[`LDSF_PRI_SAFE] <= failsafe_mode;
         primary_r[`LDSF_PRI_OUT] <= open_fault || short_fault;
         primary_r[`LDSF_PRI_PRE] <= thermal_prewarn;
         primary_r[`LDSF_PRI_TSD] <= thermal_shutdown;
         primary_r[`LDSF_PRI_POR] <= por_flag_r;
         primary_r[`LDSF_PRI_ERR] <= err_now || por_flag_r;
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         error_out <= 1'b0;
      end else begin
         error_out <= err_now;
      end
   end

   // ***********************************
   // secondary status and measurement
   // ***********************************
   logic       done_flag_r;
   ldsf_byte_t supply_r;
   ldsf_byte_t result_r;

   always_ff @(posedge clock) begin
      nvm_fail_r <= nvm_check_fail;
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         done_flag_r <= 1'b0;
      end else if (conversion_complete) begin
         done_flag_r <= 1'b1;
      end else if (rd_result) begin
         done_flag_r <= 1'b0;
      end
   end

   // ***********************************
   // conversion results
   // ***********************************
   // no reset: undetermined until the first supply conversion
   // latest supply conversion
   always_ff @(posedge clock) begin
      if (conversion_complete && conversion_is_supply) begin
         supply_r <= conversion_value;
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         result_r <= 8'h00;
      end else if (conversion_complete) begin
         result_r <= conversion_value;
      end
   end

   ldsf_byte_t secondary;

   always_comb begin
      secondary                 = 8'h00;
      secondary[`LDSF_SEC_PIN]  = failsafe_pin_level;
      secondary[`LDSF_SEC_PROG] = nvm_program_done;
      secondary[`LDSF_SEC_LOW]  = low_supply;
      secondary[`LDSF_SEC_DONE] = done_flag_r;
      secondary[`LDSF_SEC_DIAG] = diag_run_done;
      secondary[`LDSF_SEC_CRC]  = nvm_fail_r;
   end

   // ***********************************
   // interrupts
   // ***********************************
   logic [5:0] ev;
   logic [5:0] prev_r;
   logic [5:0] istat_r;
   logic [5:0] istat_nxt;
   logic [5:0] irq_en;

   assign ev = {ref_fault, open_fault || short_fault, thermal_shutdown,
                conversion_complete, diag_run_done, nvm_program_done};

   // sources idle low, so clearing to zero adds no false edge
   always_ff @(posedge clock) begin
      if (reset) begin
         prev_r <= 6'h00;
      end else begin
         prev_r <= ev;
      end
   end

   assign irq_en = irq_mask_r[5:0];

   // rising edges only, so a held fault does not refire after a read;
   // an event in the cycle of a read-clear still sets its bit
   for (genvar i = 0; i < 6; i++) begin : g_istat
      assign istat_nxt[i] = (istat_r[i] && !rd_istat) || (ev[i] && !prev_r[i]);
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         istat_r <= 6'h00;
      end else begin
         istat_r <= istat_nxt;
      end
   end

   // level output follows the next status, so it rises with the bit
   always_ff @(posedge clock) begin
      if (reset) begin
         irq <= 1'b0;
      end else begin
         irq <= |(istat_nxt & irq_en);
      end
   end

   // ***********************************
   // read port
   // ***********************************
   // control and unmapped offsets read as zero
   // status offsets have no write path
   always_ff @(posedge clock) begin
      if (reset) begin
         reg_rdata <= 8'h00;
      end else if (reg_read) begin
         unique case (reg_addr)
            `LDSF_OFF_PRIMARY:     reg_rdata <= primary_r;
            `LDSF_OFF_SECONDARY:   reg_rdata <= secondary;
            `LDSF_OFF_SUPPLY:      reg_rdata <= supply_r;
            `LDSF_OFF_CONV_RESULT: reg_rdata <= result_r;
            `LDSF_OFF_CONV_CHAN:   reg_rdata <= {3'h0, conversion_channel};
            `LDSF_OFF_MASK:        reg_rdata <= mask_r;
            `LDSF_OFF_IRQ_STATUS:  reg_rdata <= {2'h0, istat_r};
            `LDSF_OFF_IRQ_MASK:    reg_rdata <= irq_mask_r;
            default:               reg_rdata <= 8'h00;
         endcase
      end else begin
         reg_rdata <= 8'h00;
      end
   end

endmodule

// file: tb/ldsf_status_flags_props.sv
/* port checker of the status flag group.
   bound to every ldsf_status_flags instance, sees its ports only. */
`timescale 1ns/1ps
module ldsf_status_flags_props #(
   parameter int CHAN_W = 5
) (
   input wire logic       clock,
   input wire logic       reset,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic       reg_write,
   input wire logic       reg_read,
   input wire logic [7:0] reg_rdata,
   input wire logic       ref_fault,
   input wire logic       failsafe_mode,
   input wire logic       open_fault,
   input wire logic       short_fault,
   input wire logic       thermal_prewarn,
   input wire logic       thermal_shutdown,
   input wire logic       failsafe_input_pin,
   input wire logic       nvm_program_done,
   input wire logic       low_supply,
   input wire logic       diag_run_done,
   input wire logic       conversion_start,
   input wire logic [4:0] conversion_channel
);
   // ****
   // helpers
   // ****
   default clocking @(posedge clock); endclocking
   default disable iff (reset);
   wire       rd70   = reg_read && reg_addr == 8'h70;
   wire       rd71   = reg_read && reg_addr == 8'h71;
   wire       wch    = reg_write && reg_addr == 8'h62;
   wire [4:0] pri_in = {ref_fault, failsafe_mode, open_fault | short_fault,
                        thermal_prewarn, thermal_shutdown};
   wire [2:0] sec_in = {nvm_program_done, low_supply, diag_run_done};
   // inputs held long enough to pass the sync flops
   sequence s_pin_still; $stable(failsafe_input_pin) [*4]; endsequence
   sequence s_pri_still; $stable(pri_in) [*2]; endsequence
   sequence s_sec_still; $stable(sec_in) [*2]; endsequence
   // ****
   // properties
   // ****
   property p_rd_idle; !$past(reg_read) |-> reg_rdata == 8'h00; endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
   property p_start;
      wch |=> conversion_start && conversion_channel == $past(reg_wdata[4:0]);
   endproperty
   a_start: assert property (p_start) else $error("no start after write");
   property p_start_src; conversion_start |-> $past(wch); endproperty
   a_start_src: assert property (p_start_src) else $error("stray start");
   property p_pin;
      s_pin_still ##0 rd71 |=> reg_rdata[5] == $past(failsafe_input_pin);
   endproperty
   a_pin: assert property (p_pin) else $error("pin level wrong");
   property p_resv; rd71 |=> reg_rdata[7:6] == 2'b00; endproperty
   a_resv: assert property (p_resv) else $error("reserved bits set");
   property p_pri_flt;
      s_pri_still ##0 rd70 |=> reg_rdata[6:4] == $past(pri_in[4:2]);
   endproperty
   a_pri_flt: assert property (p_pri_flt) else $error("fault bits wrong");
   property p_therm;
      s_pri_still ##0 rd70 |=> reg_rdata[3:2] == $past(pri_in[1:0]);
   endproperty
   a_therm: assert property (p_therm) else $error("thermal bits wrong");
   property p_sec_lvl;
      s_sec_still ##0 rd71 |=> {reg_rdata[4:3], reg_rdata[1]} == $past(sec_in);
   endproperty
   a_sec_lvl: assert property (p_sec_lvl) else $error("event bits wrong");
endmodule

bind ldsf_status_flags ldsf_status_flags_props #(.CHAN_W(CHAN_W)) u_props (
   .clock, .reset, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
   .ref_fault, .failsafe_mode, .open_fault, .short_fault, .thermal_prewarn,
   .thermal_shutdown, .failsafe_input_pin, .nvm_program_done, .low_supply,
   .diag_run_done, .conversion_start, .conversion_channel
);

// file: tb/ldsf_host_model.sv
/* host side of the register port: one-cycle strobes.
   assumes read data stand in the cycle after the read strobe. */
`timescale 1ns/1ps
module ldsf_host_model (
   input  wire logic       clock,
   output logic [7:0]      reg_addr,
   output logic [7:0]      reg_wdata,
   output logic            reg_write,
   output logic            reg_read,
   input  wire logic [7:0] reg_rdata
);
   // ****
   // bus cycles
   // ****
   initial begin
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_write = 1'b0;
      reg_read = 1'b0;
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge clock);
      reg_write <= 1'b0;
      // stale data inverted so nothing leans on it
      reg_wdata <= ~d;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clock);
      reg_read <= 1'b0;
      @(posedge clock);
      d = reg_rdata;
   endtask
endmodule

// file: tb/ldsf_status_flags_test.sv
/* self-checking bench of the status flag group.
   assumes the host model and the checker are compiled before it. */
`timescale 1ns/1ps
module ldsf_status_flags_test import ldsf_pkg::*;;
   logic       clock;
   logic       reset;
   ldsf_byte_t addr, wdata, rdata, d, conv_val;
   logic       wr_s, rd_s, conv_done, conv_sup, start, err, irq;
   logic [5:0] flt;
   logic [4:0] ev;
   ldsf_chan_t chan;
   int         fails;
   int         tests_run;

   ldsf_host_model u_host (.clock, .reg_addr(addr), .reg_wdata(wdata),
      .reg_write(wr_s), .reg_read(rd_s), .reg_rdata(rdata));

   ldsf_status_flags u_dut (.clock, .reset, .reg_addr(addr), .reg_wdata(wdata),
      .reg_write(wr_s), .reg_read(rd_s), .reg_rdata(rdata),
      .ref_fault(flt[5]), .failsafe_mode(flt[4]), .open_fault(flt[3]),
      .short_fault(flt[2]), .thermal_prewarn(flt[1]), .thermal_shutdown(flt[0]),
      .failsafe_input_pin(ev[4]), .nvm_program_done(ev[3]), .low_supply(ev[2]),
      .diag_run_done(ev[1]), .nvm_check_fail(ev[0]),
      .conversion_complete(conv_done), .conversion_value(conv_val),
      .conversion_is_supply(conv_sup), .conversion_start(start),
      .conversion_channel(chan), .error_out(err), .irq(irq));

   // ****
   // helpers
   // ****
   task automatic chk(input ldsf_byte_t got, input ldsf_byte_t exp);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic stop_test;
      if (fails == 0 && tests_run > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // ****
   // scenarios
   // ****
   task automatic t_reset;
      u_host.rd(8'h70, d);
      chk(d, 8'h03);
      u_host.rd(8'h71, d);
      chk(d, 8'h00);
      u_host.wr(8'h70, 8'hFF);
      u_host.rd(8'h70, d);
      chk(d, 8'h03);
      u_host.wr(8'h7C, 8'h01);
      u_host.rd(8'h70, d);
      chk(d, 8'h00);
   endtask

   task automatic t_faults;
      ldsf_byte_t ex [6];
      ex = '{8'h40, 8'h20, 8'h10, 8'h10, 8'h08, 8'h04};
      for (int i = 0; i < 6; i++) begin
         flt <= 6'h20 >> i;
         repeat (3) @(posedge clock);
         u_host.rd(8'h70, d);
         chk(d & 8'hFE, ex[i]);
      end
      flt <= 6'h20;
      repeat (3) @(posedge clock);
      chk({7'h00, err}, 8'h01);
      u_host.rd(8'h70, d);
      chk(d, 8'h41);
      u_host.wr(8'h64, 8'h80);
      repeat (3) @(posedge clock);
      chk({7'h00, err}, 8'h00);
      flt <= 6'h00;
   endtask

   task automatic t_events;
      ev <= 5'h1F;
      repeat (4) @(posedge clock);
      u_host.rd(8'h71, d);
      chk(d, 8'h3B);
      u_host.wr(8'h71, 8'h00);
      u_host.rd(8'h71, d);
      chk(d, 8'h3B);
      ev <= 5'h00;
      repeat (4) @(posedge clock);
      u_host.rd(8'h71, d);
      chk(d, 8'h00);
   endtask

   task automatic t_conv;
      u_host.wr(8'h7E, 8'h04);
      u_host.wr(8'h62, 8'h25);
      #1;
      chk({start, 2'h0, chan}, 8'h85);
      chk({7'h00, irq}, 8'h00);
      @(posedge clock);
      conv_done <= 1'b1;
      conv_val <= 8'hA5;
      conv_sup <= 1'b1;
      @(posedge clock);
      conv_done <= 1'b0;
      conv_val <= 8'h5A;
      conv_sup <= 1'b0;
      repeat (2) @(posedge clock);
      chk({7'h00, irq}, 8'h01);
      u_host.rd(8'h71, d);
      chk(d & 8'h04, 8'h04);
      u_host.rd(8'h72, d);
      chk(d, 8'hA5);
      u_host.wr(8'h72, 8'h00);
      u_host.rd(8'h73, d);
      chk(d, 8'hA5);
      u_host.rd(8'h72, d);
      chk(d, 8'hA5);
      u_host.rd(8'h71, d);
      chk(d & 8'h04, 8'h00);
      u_host.rd(8'h7D, d);
      chk(d & 8'h04, 8'h04);
      repeat (2) @(posedge clock);
      chk({7'h00, irq}, 8'h00);
      u_host.rd(8'h10, d);
      chk(d, 8'h00);
   endtask

   // ****
   // run
   // ****
   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end

   initial begin
      reset = 1'b1;
      flt = 6'h00;
      ev = 5'h00;
      conv_done = 1'b0;
      conv_val = 8'h00;
      conv_sup = 1'b0;
      fails = 0;
      tests_run = 0;
      repeat (12) @(posedge clock);
      reset <= 1'b0;
      t_reset();
      t_faults();
      t_events();
      t_conv();
      stop_test();
   end

   // hang guard, far above the run length
   initial begin
      #100000;
      fails++;
      stop_test();
   end
endmodule
